/* host_model.sv */
// Purpose: Host controller model driving the register byte port
// Assumes: Requests change 2 ns after the rising edge and hold through it
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic ptr_load,
  output logic [7:0] ptr_value,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  // Answers
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // ------------------------------------------------------------------
  // Idle state and transfers
  // ------------------------------------------------------------------
  initial begin
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end

  // Load the pointer; the address line is scrambled once released
  task automatic set_ptr(input logic [7:0] a);
    @(posedge clk) #2;
    ptr_load = 1'b1;
    ptr_value = a;
    @(posedge clk) #2;
    ptr_load = 1'b0;
    ptr_value = ~a;
  endtask : set_ptr

  // One data byte; a whole byte per strobe, never a burst on layout change
  task automatic wr_byte(input logic [7:0] v);
    @(posedge clk) #2;
    wr_stb = 1'b1;
    wr_data = v;
    @(posedge clk) #2;
    wr_stb = 1'b0;
    wr_data = ~v;
  endtask : wr_byte

  // One read; the answer stands for exactly the cycle after the taking edge
  task automatic rd_byte(output logic [7:0] d, output logic v);
    @(posedge clk) #2;
    rd_stb = 1'b1;
    @(posedge clk) #2;
    rd_stb = 1'b0;
    v = rd_valid;
    d = rd_data;
  endtask : rd_byte
endmodule : host_model

/* ioc_and_device_config.sv */
// Purpose: Change-interrupt configuration and device configuration for two ports
// Assumes: Serial front end on clk presents pointer loads and byte strobes
// Notes:   Registers outside this block read as zero through this path
//
// Summary of operation
// - Enable bit gates change interrupt per pin
// - Default mode fires when pin opposes default
// - Source bit picks default or previous level
// - Bank set: ports at 00-0A and 10-1A
// - Bank clear: registers interleaved, 00 to 15
// - Layout change acts at once, pointer advances as for any byte
// - Merge set: either port drives both outputs
// - Merge clear: each output follows its port
// - Pointer advances per byte unless disabled
// - Slew disable bit turns off SDA limiting
// - Address follows pins when enabled, else zero; with SPI_VARIANT clear it always follows pins
// - Open-drain bit overrides polarity on outputs
// - Polarity bit picks active high or low
// - Config bit 0 reads zero, ignores writes
// - Per-port interrupt cleared by port/capture read
// - Flag bits mark the pins that fired
`timescale 1ns/1ns
module ioc_and_device_config #(
  parameter bit SPI_VARIANT = 1'b1  // Address enable bit acts only on this variant
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte port from the serial front end
  input wire logic ptr_load,
  input wire logic [ioc_cfg_pkg::PTR_W-1:0] ptr_value,
  input wire logic wr_stb,
  input wire logic [ioc_cfg_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_stb,
  output logic [ioc_cfg_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [ioc_cfg_pkg::PTR_W-1:0] addr_ptr,
  // Port pins
  input wire logic [ioc_cfg_pkg::DATA_W-1:0] first_port,
  input wire logic [ioc_cfg_pkg::DATA_W-1:0] second_port,
  // Address pins and serial pin control
  input wire logic addr_pin_two,
  input wire logic addr_pin_one,
  input wire logic addr_pin_zero,
  output logic [ioc_cfg_pkg::HWADDR_W-1:0] hw_addr,
  output logic sda_slew_limit,
  // Interrupt outputs
  output logic irq_out_a,
  output logic irq_out_a_oe,
  output logic irq_out_b,
  output logic irq_out_b_oe
);

  localparam int W = ioc_cfg_pkg::DATA_W;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [W-1:0] pa_meta_q, pa_q;   // First port, two stages
  logic [W-1:0] pb_meta_q, pb_q;   // Second port, two stages
  logic [2:0] ad_meta_q, ad_q;     // Address pins, two stages

  // Only the second stage is read by logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_meta_q <= '0;
      pa_q <= '0;
      pb_meta_q <= '0;
      pb_q <= '0;
      ad_meta_q <= '0;
      ad_q <= '0;
    end else begin
      pa_meta_q <= first_port;
      pa_q <= pa_meta_q;
      pb_meta_q <= second_port;
      pb_q <= pb_meta_q;
      ad_meta_q <= {addr_pin_two, addr_pin_one, addr_pin_zero};
      ad_q <= ad_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [W-1:0] en_q [2];     // pin_change_irq_enable per port
  logic [W-1:0] def_q [2];    // compare_default_value per port
  logic [W-1:0] sel_q [2];    // compare_source_select per port
  logic [W-1:0] cfg_q;        // device_configuration, shared by both ports
  logic [W-1:0] flags [2];
  logic [W-1:0] capt [2];
  logic [1:0] pend;
  logic [1:0] clr;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic dec_ok;               // Pointer lands on a mapped location
  logic dec_port;             // 0 first port, 1 second port
  logic [4:0] dec_idx;        // Per-port register index

  // Decode follows the live bank bit, so a layout write acts on the next byte
  always_comb begin
    dec_ok = 1'b0;
    dec_port = 1'b0;
    dec_idx = '0;
    if (cfg_q[ioc_cfg_pkg::CFG_BANK]) begin
      if (addr_ptr <= 8'({3'b000, ioc_cfg_pkg::IDX_LAST})) begin
        dec_ok = 1'b1;
        dec_idx = addr_ptr[4:0];
      end else if (addr_ptr >= ioc_cfg_pkg::BANKED_B_BASE
                   && addr_ptr <= ioc_cfg_pkg::BANKED_B_LAST) begin
        dec_ok = 1'b1;
        dec_port = 1'b1;
        dec_idx = {1'b0, addr_ptr[3:0]};
      end
    end else if (addr_ptr <= ioc_cfg_pkg::PAIRED_LAST) begin
      dec_ok = 1'b1;
      dec_port = addr_ptr[0];
      dec_idx = {1'b0, addr_ptr[4:1]};
    end
  end

  // ----------------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------------
  // Loaded by the front end; layout writes advance it like any other byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ptr <= ioc_cfg_pkg::RST_PTR;
    end else if (ptr_load) begin
      addr_ptr <= ptr_value;
    end else if ((wr_stb || rd_stb) && !cfg_q[ioc_cfg_pkg::CFG_SEQ_DIS]) begin
      addr_ptr <= addr_ptr + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  logic wr_go;                // Write accepted this cycle
  assign wr_go = wr_stb && !ptr_load && dec_ok;

  // Per-port configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < 2; p++) begin
        en_q[p] <= ioc_cfg_pkg::RST_REG;
        def_q[p] <= ioc_cfg_pkg::RST_REG;
        sel_q[p] <= ioc_cfg_pkg::RST_REG;
      end
    end else if (wr_go) begin
      case (dec_idx)
        ioc_cfg_pkg::IDX_IRQ_ENABLE: en_q[dec_port] <= wr_data;
        ioc_cfg_pkg::IDX_DEFAULT: def_q[dec_port] <= wr_data;
        ioc_cfg_pkg::IDX_SOURCE_SEL: sel_q[dec_port] <= wr_data;
        default: ;  // Config is written below; others read-only or outside this block
      endcase
    end
  end

  // Configuration register, reachable from either port's address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= ioc_cfg_pkg::RST_REG;
    end else if (wr_go && dec_idx == ioc_cfg_pkg::IDX_CONFIG) begin
      cfg_q <= wr_data & ioc_cfg_pkg::CFG_WR_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  logic rd_go;                // Read accepted this cycle
  logic [W-1:0] rd_mux;
  assign rd_go = rd_stb && !ptr_load && !wr_stb;

  // Unmapped and out-of-block locations return zero
  always_comb begin
    rd_mux = '0;
    if (dec_ok) begin
      case (dec_idx)
        ioc_cfg_pkg::IDX_IRQ_ENABLE: rd_mux = en_q[dec_port];
        ioc_cfg_pkg::IDX_DEFAULT: rd_mux = def_q[dec_port];
        ioc_cfg_pkg::IDX_SOURCE_SEL: rd_mux = sel_q[dec_port];
        ioc_cfg_pkg::IDX_CONFIG: rd_mux = cfg_q;
        ioc_cfg_pkg::IDX_FLAG: rd_mux = flags[dec_port];
        ioc_cfg_pkg::IDX_CAPTURE: rd_mux = capt[dec_port];
        ioc_cfg_pkg::IDX_PORT: rd_mux = dec_port ? pb_q : pa_q;
        default: rd_mux = '0;
      endcase
    end
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_go;
      if (rd_go) begin
        rd_data <= rd_mux;
      end
    end
  end

  // A read of port value or capture clears that port's interrupt only
  always_comb begin
    clr = 2'b00;
    if (rd_go && dec_ok && (dec_idx == ioc_cfg_pkg::IDX_PORT
        || dec_idx == ioc_cfg_pkg::IDX_CAPTURE)) begin
      clr[dec_port] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Per-port change detection
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    ioc_port_unit #(.W(W)) u_unit (
      .clk(clk),
      .nrst(nrst),
      .pin_level(p == 0 ? pa_q : pb_q),
      .irq_enable(en_q[p]),
      .compare_default(def_q[p]),
      .compare_sel(sel_q[p]),
      .clear_stb(clr[p]),
      .flags_q(flags[p]),
      .capture_q(capt[p]),
      .pending_q(pend[p])
    );
  end

  // ----------------------------------------------------------------------
  // Interrupt output drivers
  // ----------------------------------------------------------------------
  logic act_a, act_b;         // Active request per output
  logic mir, od, pol;
  assign mir = cfg_q[ioc_cfg_pkg::CFG_MIRROR];
  assign od = cfg_q[ioc_cfg_pkg::CFG_OPEN_DRAIN];
  assign pol = cfg_q[ioc_cfg_pkg::CFG_ACT_LEVEL];
  assign act_a = pend[0] || (mir && pend[1]);
  assign act_b = pend[1] || (mir && pend[0]);

  // Open drain pulls low only while active; push-pull always drives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_out_a <= 1'b1;
      irq_out_b <= 1'b1;
      irq_out_a_oe <= 1'b1;
      irq_out_b_oe <= 1'b1;
    end else if (od) begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
      irq_out_a_oe <= act_a;
      irq_out_b_oe <= act_b;
    end else begin
      irq_out_a <= act_a ~^ pol;
      irq_out_b <= act_b ~^ pol;
      irq_out_a_oe <= 1'b1;
      irq_out_b_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Serial pin controls
  // ----------------------------------------------------------------------
  // Registered so the front end sees glitch-free levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hw_addr <= '0;
      sda_slew_limit <= 1'b1;
    end else begin
      sda_slew_limit <= !cfg_q[ioc_cfg_pkg::CFG_SLEW_DIS];
      hw_addr <= (!SPI_VARIANT || cfg_q[ioc_cfg_pkg::CFG_ADDR_EN]) ? ad_q : 3'b000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_merge;
    @(posedge clk) disable iff (!nrst)
      (!od && pol && mir && (|pend)) |=> (irq_out_a && irq_out_b);
  endproperty
  a_merge: assert property (p_merge)
    else $error("merged outputs not both active");

  property p_split;
    @(posedge clk) disable iff (!nrst)
      (!od && !mir && pend == 2'b01) |=> (irq_out_a == $past(pol) && irq_out_b != $past(pol));
  endproperty
  a_split: assert property (p_split)
    else $error("unmerged output driven by other port");

  property p_open_drain;
    @(posedge clk) disable iff (!nrst)
      od |=> (!irq_out_a && irq_out_a_oe == $past(act_a) && !irq_out_b);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain output misdriven");

  property p_polarity;
    @(posedge clk) disable iff (!nrst)
      !od |=> (irq_out_a_oe && irq_out_a == ($past(act_a) ~^ $past(pol)));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("push-pull level wrong for polarity");

  property p_cfg_bit0;
    @(posedge clk) disable iff (!nrst)
      rd_go && dec_ok && dec_idx == ioc_cfg_pkg::IDX_CONFIG |=> rd_valid && !rd_data[0];
  endproperty
  a_cfg_bit0: assert property (p_cfg_bit0)
    else $error("config bit 0 read as one");

  property p_ptr_hold;
    @(posedge clk) disable iff (!nrst)
      (rd_stb && !ptr_load && cfg_q[ioc_cfg_pkg::CFG_SEQ_DIS]) |=> $stable(addr_ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved with auto-increment off");

  property p_hw_addr;
    @(posedge clk) disable iff (!nrst)
      (SPI_VARIANT && !cfg_q[ioc_cfg_pkg::CFG_ADDR_EN]) |=> (hw_addr == 3'b000);
  endproperty
  a_hw_addr: assert property (p_hw_addr)
    else $error("hardware address not zero when disabled");

  property p_slew;
    @(posedge clk) disable iff (!nrst)
      ##1 (sda_slew_limit == !$past(cfg_q[ioc_cfg_pkg::CFG_SLEW_DIS]));
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew control does not follow config");

  c_merge: cover property (@(posedge clk) disable iff (!nrst) mir && pend == 2'b10);
  c_bank_switch: cover property (@(posedge clk) disable iff (!nrst)
    wr_go && dec_idx == ioc_cfg_pkg::IDX_CONFIG && wr_data[ioc_cfg_pkg::CFG_BANK]);
  c_clear_read: cover property (@(posedge clk) disable iff (!nrst) |clr);

endmodule : ioc_and_device_config

/* ioc_and_device_config_tb_top.sv */
// Purpose: Self-checking bench for the change-interrupt and configuration block
// Assumes: Paired layout after reset; outputs sampled 3 ns after the edge
// Notes:   Output vector is {out_a, oe_a, out_b, oe_b}
`timescale 1ns/1ns
module ioc_and_device_config_tb_top;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ptr_load, wr_stb, rd_stb, rd_valid;
  logic [7:0] ptr_value, wr_data, rd_data, addr_ptr;
  logic [7:0] first_port = 8'h00;
  logic [7:0] second_port = 8'h00;
  logic [2:0] apins = 3'h0;  // {two, one, zero}
  logic [2:0] hw_addr;
  logic sda_slew_limit, irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe;
  logic [3:0] outs;
  int err_count = 0;
  int checked = 0;
  int i;

  assign outs = {irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe};
  always #25 clk = ~clk;  // 20 MHz

  // ------------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------------
  ioc_and_device_config dut (.clk(clk), .nrst(nrst), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_data(rd_data), .rd_valid(rd_valid), .addr_ptr(addr_ptr),
    .first_port(first_port), .second_port(second_port), .addr_pin_two(apins[2]),
    .addr_pin_one(apins[1]), .addr_pin_zero(apins[0]), .hw_addr(hw_addr),
    .sda_slew_limit(sda_slew_limit), .irq_out_a(irq_out_a),
    .irq_out_a_oe(irq_out_a_oe), .irq_out_b(irq_out_b), .irq_out_b_oe(irq_out_b_oe));
  host_model host (.clk(clk), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
    .rd_valid(rd_valid));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.set_ptr(a);
    host.wr_byte(v);
  endtask : wr

  // Read one location; rd_valid must answer in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.set_ptr(a);
    host.rd_byte(d, v);
    check({7'h00, v}, 8'h01);
    check(d, e);
  endtask : rd_chk

  // Bounded wait for the interrupt outputs; a hang ends the run
  task automatic wait_out(input logic [3:0] e);
    for (int k = 0; k < 12; k++) begin
      @(posedge clk) #3;
      if (outs === e) break;
    end
    check({4'h0, outs}, {4'h0, e});
    if (outs !== e) tally_and_finish();
  endtask : wait_out

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #2 nrst = 1'b1;
    check({4'h0, outs}, 8'h0F);  // Push-pull active-low idle
    check({7'h00, sda_slew_limit}, 8'h01);
    for (i = 4; i <= 11; i++) rd_chk(i[7:0], 8'h00);  // Reset values
    for (i = 4; i <= 9; i++) wr(i[7:0], 8'h30 | i[7:0]);  // Paired writes
    check(addr_ptr, 8'h0A);  // Pointer advanced past the byte
    for (i = 4; i <= 9; i++) rd_chk(i[7:0], 8'h30 | i[7:0]);
    for (i = 4; i <= 9; i++) wr(i[7:0], 8'h00);
    // Select writes armed default compare on low pins, so both ports fired
    rd_chk(8'h0E, 8'h30);  // Enabled pins opposing default
    rd_chk(8'h0F, 8'h31);
    rd_chk(8'h10, 8'h00);  // Capture A read clears A
    rd_chk(8'h11, 8'h00);  // Capture B read clears B
    // Config bit 0, hold pointer, slew and address pins
    wr(8'h0A, 8'h21);
    rd_chk(8'h0B, 8'h20);  // Bit 0 dropped
    check(addr_ptr, 8'h0B);  // Pointer held
    wr(8'h0A, 8'h18);
    apins = 3'h5;
    repeat (4) @(posedge clk);
    #3 check({5'h00, hw_addr}, 8'h05);
    check({7'h00, sda_slew_limit}, 8'h00);
    wr(8'h0A, 8'h00);
    repeat (4) @(posedge clk);
    #3 check({5'h00, hw_addr}, 8'h00);
    // Previous-level compare on port A, one pin enabled
    wr(8'h06, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h01);
    @(posedge clk) #2 first_port = 8'h03;
    wait_out(4'h7);  // A only, active low
    rd_chk(8'h0E, 8'h01);  // Flag marks pin 0 only
    rd_chk(8'h10, 8'h03);  // Capture read clears
    wait_out(4'hF);
    @(posedge clk) #2 first_port = 8'h01;
    repeat (8) @(posedge clk);
    #3 check({4'h0, outs}, 8'h0F);  // Disabled pin stays quiet
    // Default compare on port B, merged, active high
    wr(8'h05, 8'h80);
    wr(8'h07, 8'h00);
    wr(8'h09, 8'h80);
    wr(8'h0A, 8'h42);
    wait_out(4'h5);
    @(posedge clk) #2 second_port = 8'h80;
    wait_out(4'hF);  // Both outputs from port B
    rd_chk(8'h0F, 8'h80);
    wr(8'h07, 8'h80);
    rd_chk(8'h13, 8'h80);  // Port read clears
    wait_out(4'h5);
    // Open drain overrides polarity; B pending, not merged
    wr(8'h0A, 8'h06);
    @(posedge clk) #2 second_port = 8'h00;
    wait_out(4'h1);
    // Segregated layout takes effect at once, pointer advanced by the write as usual
    wr(8'h0A, 8'h80);  // Single-byte write
    check(addr_ptr, 8'h0B);
    rd_chk(8'h05, 8'h80);
    rd_chk(8'h12, 8'h80);
    rd_chk(8'h14, 8'h80);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h15, 8'h80);
    tally_and_finish();
  end
endmodule : ioc_and_device_config_tb_top

/* ioc_cfg_pkg.sv */
// Purpose: Shared constants for the change-interrupt and configuration block
// Assumes: Byte-wide registers reached through an internal address pointer
// Notes:   Register indices are per-port offsets; the bank bit maps them to addresses
package ioc_cfg_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;            // Register and port width
  localparam int PTR_W = 8;             // Address pointer width
  localparam int HWADDR_W = 3;          // Hardware address pins

  // ----------------------------------------------------------------------
  // Per-port register indices (segregated layout offsets)
  // ----------------------------------------------------------------------
  localparam logic [4:0] IDX_IRQ_ENABLE = 5'h02;   // pin_change_irq_enable
  localparam logic [4:0] IDX_DEFAULT = 5'h03;      // compare_default_value
  localparam logic [4:0] IDX_SOURCE_SEL = 5'h04;   // compare_source_select
  localparam logic [4:0] IDX_CONFIG = 5'h05;       // device_configuration
  localparam logic [4:0] IDX_FLAG = 5'h07;         // irq_flag_register
  localparam logic [4:0] IDX_CAPTURE = 5'h08;      // irq_capture_register
  localparam logic [4:0] IDX_PORT = 5'h09;         // pin value register
  localparam logic [4:0] IDX_LAST = 5'h0A;         // Highest per-port index

  // ----------------------------------------------------------------------
  // Address map bounds
  // ----------------------------------------------------------------------
  localparam logic [7:0] BANKED_B_BASE = 8'h10;    // Second port base, banked
  localparam logic [7:0] BANKED_B_LAST = 8'h1A;    // Second port top, banked
  localparam logic [7:0] PAIRED_LAST = 8'h15;      // Top of paired map

  // ----------------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------------
  localparam int CFG_BANK = 7;          // Map layout
  localparam int CFG_MIRROR = 6;        // Interrupt output merge
  localparam int CFG_SEQ_DIS = 5;       // pointer_autoinc_disable
  localparam int CFG_SLEW_DIS = 4;      // sda_slew_disable
  localparam int CFG_ADDR_EN = 3;       // addr_pin_enable
  localparam int CFG_OPEN_DRAIN = 2;    // irq_open_drain
  localparam int CFG_ACT_LEVEL = 1;     // irq_active_level
  localparam logic [7:0] CFG_WR_MASK = 8'hFE;  // Bit 0 unimplemented

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;      // All block registers
  localparam logic [7:0] RST_PTR = 8'h00;      // Address pointer

endpackage : ioc_cfg_pkg

/* ioc_port_unit.sv */
// Purpose: Change detection, flags, capture and pending signal for one port
// Assumes: Pin levels already synchronised to clk
// Notes:   A new event in the clearing cycle wins over the clear
`timescale 1ns/1ns
module ioc_port_unit #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Synchronised pins and configuration
  input wire logic [W-1:0] pin_level,
  input wire logic [W-1:0] irq_enable,
  input wire logic [W-1:0] compare_default,
  input wire logic [W-1:0] compare_sel,
  // Read of port or capture register
  input wire logic clear_stb,
  // State
  output logic [W-1:0] flags_q,
  output logic [W-1:0] capture_q,
  output logic pending_q
);

  // ----------------------------------------------------------------------
  // Compare logic
  // ----------------------------------------------------------------------
  logic [W-1:0] prev_q;     // Pin level one cycle ago
  logic [W-1:0] mismatch;   // Enabled pins whose compare fails
  logic fire;               // Event taken this cycle

  // Reference is the stored default or the previous level, per pin
  assign mismatch = irq_enable & (pin_level ^ ((compare_sel & compare_default)
                    | (~compare_sel & prev_q)));
  // Only the first event is latched until the host clears it
  assign fire = (!pending_q || clear_stb) && (|mismatch);

  // Previous level tracks the pins every cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= '0;
    end else begin
      prev_q <= pin_level;
    end
  end

  // Flag, capture and pending; set beats clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
      capture_q <= '0;
      pending_q <= 1'b0;
    end else if (fire) begin
      flags_q <= mismatch;
      capture_q <= pin_level;
      pending_q <= 1'b1;
    end else if (clear_stb) begin
      flags_q <= '0;
      pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_masked_no_flag;
    @(posedge clk) disable iff (!nrst)
      $rose(pending_q) |-> ((flags_q & ~$past(irq_enable)) == '0);
  endproperty
  a_masked_no_flag: assert property (p_masked_no_flag)
    else $error("flag set on a disabled pin");

  property p_default_fires;
    @(posedge clk) disable iff (!nrst)
      (!pending_q && irq_enable[0] && compare_sel[0] && (pin_level[0] != compare_default[0]))
      |=> (pending_q && flags_q[0]);
  endproperty
  a_default_fires: assert property (p_default_fires)
    else $error("default mismatch did not raise interrupt");

  property p_prev_fires;
    @(posedge clk) disable iff (!nrst)
      (!pending_q && irq_enable[0] && !compare_sel[0] && (pin_level[0] != prev_q[0]))
      |=> (pending_q && flags_q[0] && capture_q[0] == $past(pin_level[0]));
  endproperty
  a_prev_fires: assert property (p_prev_fires)
    else $error("pin change did not raise interrupt");

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (clear_stb && mismatch == '0) |=> (!pending_q && flags_q == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("read did not clear interrupt");

  property p_flag_source;
    @(posedge clk) disable iff (!nrst)
      $rose(pending_q) |-> (flags_q != '0);
  endproperty
  a_flag_source: assert property (p_flag_source)
    else $error("interrupt without source flag");

  c_set_beats_clear: cover property (@(posedge clk) disable iff (!nrst)
    pending_q && clear_stb && (|mismatch) ##1 pending_q);

endmodule : ioc_port_unit
